// ---- fce_pkg.sv ----
// Purpose: Shared constants and types for the status-flag and condition block.
// Assumes: APB with 32-bit data; one aligned word per register.
// Notes: Offsets are byte addresses on the APB side.
package fce_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] FCE_FLAGS_INDEX = 8'he7;
    localparam logic [11:0] FCE_FLAGS_ADDR = 12'h39c;
    localparam logic [11:0] FCE_OP_ADDR = 12'h400;
    localparam logic [11:0] FCE_RES_ADDR = 12'h404;
    localparam logic [11:0] FCE_COND_ADDR = 12'h408;
    localparam logic [11:0] FCE_OPND_ADDR = 12'h40c;
    localparam logic [11:0] FCE_NOTATION_ADDR = 12'h410;

    // ------------------------------------------------------------
    // Flag bit positions
    // ------------------------------------------------------------
    localparam int FCE_C_BIT = 7;
    localparam int FCE_Z_BIT = 6;
    localparam int FCE_S_BIT = 5;
    localparam int FCE_V_BIT = 4;
    localparam int FCE_D_BIT = 3;
    localparam int FCE_H_BIT = 2;
    localparam int FCE_U_BIT = 1;
    localparam int FCE_M_BIT = 0;
    localparam logic [7:0] FCE_FLAGS_RESET = 8'h00;

    // ------------------------------------------------------------
    // Operand range limits
    // ------------------------------------------------------------
    localparam logic [7:0] FCE_WORK_REG_MAX = 8'h0f;
    localparam logic [7:0] FCE_DIR_REG_MAX = 8'hff;

    // Operation codes issued by the decoder.
    typedef enum logic [4:0] {
        FCE_OP_NONE = 5'h00, FCE_OP_ADD = 5'h01, FCE_OP_ADC = 5'h02,
        FCE_OP_SUB = 5'h03, FCE_OP_SBC = 5'h04, FCE_OP_CP = 5'h05,
        FCE_OP_LOGIC = 5'h06, FCE_OP_INCDEC = 5'h07, FCE_OP_TEST = 5'h08,
        FCE_OP_SRA = 5'h09, FCE_OP_ROT = 5'h0a, FCE_OP_BCD = 5'h0b,
        FCE_OP_MULDIV = 5'h0c, FCE_OP_SCF = 5'h0d, FCE_OP_RCF = 5'h0e,
        FCE_OP_CCF = 5'h0f, FCE_OP_SDM = 5'h10, FCE_OP_SPM = 5'h11,
        FCE_OP_SETU = 5'h12, FCE_OP_CLRU = 5'h13
    } fce_op_type;

    // Result of one completed ALU instruction.
    typedef struct packed {
        logic [15:0] value;
        logic carry;
        logic half;
        logic ovf;
        logic word;
        logic dst_is_flags;
    } fce_result_type;

    // Condition codes of conditional jumps.
    localparam logic [3:0] FCE_CC_F = 4'h0;
    localparam logic [3:0] FCE_CC_LT = 4'h1;
    localparam logic [3:0] FCE_CC_LE = 4'h2;
    localparam logic [3:0] FCE_CC_ULE = 4'h3;
    localparam logic [3:0] FCE_CC_OV = 4'h4;
    localparam logic [3:0] FCE_CC_MI = 4'h5;
    localparam logic [3:0] FCE_CC_Z = 4'h6;
    localparam logic [3:0] FCE_CC_C = 4'h7;
    localparam logic [3:0] FCE_CC_T = 4'h8;
    localparam logic [3:0] FCE_CC_GE = 4'h9;
    localparam logic [3:0] FCE_CC_GT = 4'ha;
    localparam logic [3:0] FCE_CC_UGT = 4'hb;
    localparam logic [3:0] FCE_CC_NOV = 4'hc;
    localparam logic [3:0] FCE_CC_PL = 4'hd;
    localparam logic [3:0] FCE_CC_NZ = 4'he;
    localparam logic [3:0] FCE_CC_NC = 4'hf;

endpackage : fce_pkg

// ---- fce_flags.sv ----
// Purpose: Status-flag register and jump condition evaluator of the core.
// Assumes: Decoder pulses op_valid once per completed instruction.
// Notes: Registers are reachable over APB for test and software access, with
//        one wait state so that pready, prdata and pslverr all leave flip-flops.
//        Masters must wait for pready rather than assume a fixed latency.
`timescale 1ns/1ps
module fce_flags (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoder and ALU side.
    input wire logic op_valid,
    input wire fce_pkg::fce_op_type op_code,
    input wire fce_pkg::fce_result_type op_result,
    input wire logic [3:0] cond_code,
    // Flag outputs toward the core.
    output logic [7:0] flags_out,
    output logic jump_taken,
    output logic data_space_sel,
    output logic flags_undefined
);
    import fce_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Condition test against a flag byte.
    function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
        logic c;
        logic z;
        logic sv;
        c = f[FCE_C_BIT];
        z = f[FCE_Z_BIT];
        sv = f[FCE_S_BIT] ^ f[FCE_V_BIT];
        case (cc)
            FCE_CC_F: cond_true = 1'b0;
            FCE_CC_T: cond_true = 1'b1;
            FCE_CC_C: cond_true = c;
            FCE_CC_NC: cond_true = ~c;
            FCE_CC_Z: cond_true = z;
            FCE_CC_NZ: cond_true = ~z;
            FCE_CC_MI: cond_true = f[FCE_S_BIT];
            FCE_CC_PL: cond_true = ~f[FCE_S_BIT];
            FCE_CC_OV: cond_true = f[FCE_V_BIT];
            FCE_CC_NOV: cond_true = ~f[FCE_V_BIT];
            FCE_CC_GE: cond_true = ~sv;
            FCE_CC_LT: cond_true = sv;
            FCE_CC_GT: cond_true = ~(z | sv);
            FCE_CC_LE: cond_true = z | sv;
            FCE_CC_UGT: cond_true = ~c & ~z;
            FCE_CC_ULE: cond_true = c | z;
            default: cond_true = 1'b0;
        endcase
    endfunction : cond_true

    // True for the instructions that load carry from the ALU result.
    function automatic logic hits_carry(input fce_op_type op);
        case (op)
            FCE_OP_ADD, FCE_OP_ADC, FCE_OP_SUB, FCE_OP_SBC, FCE_OP_CP,
            FCE_OP_SRA, FCE_OP_ROT, FCE_OP_BCD, FCE_OP_MULDIV: hits_carry = 1'b1;
            default: hits_carry = 1'b0;
        endcase
    endfunction : hits_carry

    // True for the instructions that move zero, sign and overflow.
    function automatic logic hits_zsv(input fce_op_type op);
        hits_zsv = hits_carry(op) || op == FCE_OP_LOGIC || op == FCE_OP_INCDEC
            || op == FCE_OP_TEST;
    endfunction : hits_zsv

    // True for add, subtract and compare of either width; BCD state is left only for bytes.
    function automatic logic is_addsub(input fce_op_type op);
        is_addsub = op == FCE_OP_ADD || op == FCE_OP_ADC || op == FCE_OP_SUB
            || op == FCE_OP_SBC || op == FCE_OP_CP;
    endfunction : is_addsub

    // Register decode, shared by the write strobes and the error check.
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] reg_addr);
        addr_is = a == reg_addr;
    endfunction : addr_is

    // ------------------------------------------------------------
    // Flag register
    // ------------------------------------------------------------
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic undef_ff;
    logic apb_acc;
    logic apb_wr;
    logic apb_rd;
    logic ready_ff;
    logic flags_hit;
    logic msb;
    logic is_sub;

    // First access cycle: the registered answer is prepared here.
    assign apb_acc = psel & penable & ~ready_ff;
    // A write lands only at the edge where the master sees pready high.
    assign apb_wr = psel & penable & pwrite & ready_ff;
    assign apb_rd = apb_acc & ~pwrite;
    assign flags_hit = addr_is(paddr, FCE_FLAGS_ADDR);
    // Sign source follows the operand width; direction feeds the BCD flag.
    assign msb = op_result.word ? op_result.value[15] : op_result.value[7];
    assign is_sub = op_code == FCE_OP_SUB || op_code == FCE_OP_SBC || op_code == FCE_OP_CP;

    // Next flag value; only flags the instruction touches change.
    always_comb begin
        nxt_flags = flags_ff;
        if (op_valid) begin
            if (hits_carry(op_code)) begin
                nxt_flags[FCE_C_BIT] = op_result.carry;
            end
            if (hits_zsv(op_code)) begin
                if (op_result.word) begin
                    nxt_flags[FCE_Z_BIT] = op_result.value == 16'h0000;
                end else begin
                    nxt_flags[FCE_Z_BIT] = op_result.value[7:0] == 8'h00;
                end
                nxt_flags[FCE_S_BIT] = msb;
                nxt_flags[FCE_V_BIT] = op_result.ovf;
            end
            // BCD state only follows byte add, subtract and compare.
            if (is_addsub(op_code) && !op_result.word) begin
                nxt_flags[FCE_D_BIT] = is_sub;
                nxt_flags[FCE_H_BIT] = op_result.half;
            end
            case (op_code)
                FCE_OP_SCF: nxt_flags[FCE_C_BIT] = 1'b1;
                FCE_OP_RCF: nxt_flags[FCE_C_BIT] = 1'b0;
                FCE_OP_CCF: nxt_flags[FCE_C_BIT] = ~flags_ff[FCE_C_BIT];
                FCE_OP_SDM: nxt_flags[FCE_M_BIT] = 1'b1;
                FCE_OP_SPM: nxt_flags[FCE_M_BIT] = 1'b0;
                FCE_OP_SETU: nxt_flags[FCE_U_BIT] = 1'b1;
                FCE_OP_CLRU: nxt_flags[FCE_U_BIT] = 1'b0;
                default: nxt_flags[FCE_U_BIT] = flags_ff[FCE_U_BIT];
            endcase
        end else if (apb_wr && flags_hit) begin
            nxt_flags = pwdata[7:0];
        end
    end

    // The reset value is architecturally undefined; zero is chosen here.
    // Software must not rely on it; flags_undefined stays high until an APB write of the flag register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= FCE_FLAGS_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Marks the content as undefined after an ALU write aimed at the flags.
    // The flags still take the ALU update; software must rewrite them before
    // trusting any bit, and only that rewrite clears the mark.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undef_ff <= 1'b1;
        end else if (op_valid && hits_zsv(op_code) && op_result.dst_is_flags) begin
            undef_ff <= 1'b1;
        end else if (apb_wr && flags_hit && !op_valid) begin
            undef_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Condition evaluation and outputs
    // ------------------------------------------------------------
    logic jump_ff;
    logic [3:0] last_cc_ff;

    // Registered against the committed flags; valid one cycle after cond_code.
    // Using the committed flags rather than nxt_flags keeps the decode off the
    // ALU carry chain, at the price of one cycle between an update and its test.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jump_ff <= 1'b0;
        end else begin
            jump_ff <= cond_true(cond_code, flags_ff);
        end
    end

    // Last condition field seen, kept for software inspection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_cc_ff <= FCE_CC_F;
        end else begin
            last_cc_ff <= cond_code;
        end
    end

    assign flags_out = flags_ff;
    assign jump_taken = jump_ff;
    assign data_space_sel = flags_ff[FCE_M_BIT];
    assign flags_undefined = undef_ff;

    // ------------------------------------------------------------
    // Operand notation checker
    // ------------------------------------------------------------
    // Software writes an operand word: [31:16] address of the next instruction,
    // [15:8] displacement, whose bit 8 is also the direct pair register's lsb,
    // [16] pair form, [3:0] working register, [2:0] bit index.
    // The pair flag shares bit 16 with the address lsb to fit one word.
    logic [31:0] opnd_ff;
    logic [31:0] note_ff;
    logic [15:0] pc_next;
    logic [7:0] disp;
    logic [7:0] bit_mask;
    logic opnd_ok;
    logic [15:0] target;

    // Operand word written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd_ff <= 32'h0000_0000;
        end else if (apb_wr && addr_is(paddr, FCE_OPND_ADDR)) begin
            opnd_ff <= pwdata;
        end
    end

    assign pc_next = opnd_ff[31:16];
    assign disp = opnd_ff[15:8];
    // Pairs must be even, both for working and direct registers.
    assign opnd_ok = !opnd_ff[16] || (!opnd_ff[0] && !opnd_ff[8]);
    assign target = pc_next + {{8{disp[7]}}, disp};

    // One select line per bit of the addressed byte; bit 0 is the lsb.
    generate
        for (genvar gi = 0; gi < 8; gi++) begin : g_mask
            assign bit_mask[gi] = opnd_ff[2:0] == 3'(gi);
        end
    endgenerate

    // Result word: [15:0] relative target, [16] pair legal,
    // [24:17] one-hot bit mask from bit index in [2:0].
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            note_ff <= 32'h0000_0000;
        end else begin
            note_ff <= {7'h00, bit_mask, opnd_ok, target};
        end
    end

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic known;

    // Addresses that answer without an error.
    assign known = flags_hit || addr_is(paddr, FCE_COND_ADDR) || addr_is(paddr, FCE_OPND_ADDR)
        || addr_is(paddr, FCE_NOTATION_ADDR);

    // Register select for reads; unmapped addresses read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            FCE_FLAGS_ADDR: rd_mux = {24'h00_0000, flags_ff};
            FCE_COND_ADDR: rd_mux = {22'h0, undef_ff, jump_ff, 4'h0, last_cc_ff};
            FCE_OPND_ADDR: rd_mux = opnd_ff;
            FCE_NOTATION_ADDR: rd_mux = note_ff;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait state: pready rises at the edge that ends the first access cycle and the master
    // sees it at the following edge. The cycle spent buys a flop-driven pready
    // and keeps the read mux out of the bus timing path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= apb_acc;
        end
    end

    // Read data is captured in the first access cycle, so it stands unchanged
    // through the cycle in which the master takes it, and is zero otherwise.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (apb_rd) begin
            prdata_ff <= rd_mux;
        end else begin
            prdata_ff <= 32'h0000_0000;
        end
    end

    // Error answer for unmapped addresses, timed with pready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= apb_acc & ~known;
        end
    end

    // Port drives come straight from the answer flops.
    assign prdata = prdata_ff;
    assign pready = ready_ff;
    assign pslverr = pslverr_ff;

endmodule : fce_flags

// ---- fce_flags_checker.sv ----
// Purpose: Port-level timing checks for the flag block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every fce_flags instance below the module.
`timescale 1ns/1ps
module fce_flags_checker (
    // Clock, reset and APB.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Decoder side and flag outputs.
    input wire logic op_valid,
    input wire fce_pkg::fce_op_type op_code,
    input wire fce_pkg::fce_result_type op_result,
    input wire logic [3:0] cond_code,
    input wire logic [7:0] flags_out,
    input wire logic jump_taken,
    input wire logic data_space_sel,
    input wire logic flags_undefined
);
    import fce_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // An APB write may legally change any flag, so the hold checks skip it.
    wire logic apb_wr = psel && penable && pwrite && pready;
    property p_scf; op_valid && op_code == FCE_OP_SCF |=> flags_out[FCE_C_BIT]; endproperty
    a_scf: assert property (p_scf) else $error("carry not set");
    property p_ccf; op_valid && op_code == FCE_OP_CCF |=> $changed(flags_out[FCE_C_BIT]); endproperty
    a_ccf: assert property (p_ccf) else $error("carry not inverted");
    property p_user; op_valid && !(op_code inside {FCE_OP_SETU, FCE_OP_CLRU})
        |=> $stable(flags_out[FCE_U_BIT]); endproperty
    a_user: assert property (p_user) else $error("user bit moved");
    property p_keep; !op_valid && !apb_wr |=> $stable(flags_out); endproperty
    a_keep: assert property (p_keep) else $error("flags moved while idle");
    property p_zero; op_valid && op_code == FCE_OP_ADD && !op_result.word
        |=> flags_out[FCE_Z_BIT] == ($past(op_result.value[7:0]) == 8'h00); endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_sign; op_valid && op_code == FCE_OP_SUB && op_result.word
        |=> flags_out[FCE_S_BIT] == $past(op_result.value[15]); endproperty
    a_sign: assert property (p_sign) else $error("word sign wrong");
    property p_never; cond_code == FCE_CC_F |=> !jump_taken; endproperty
    a_never: assert property (p_never) else $error("false code jumped");
    property p_always; cond_code == FCE_CC_T |=> jump_taken; endproperty
    a_always: assert property (p_always) else $error("true code idle");
    property p_carry; cond_code == FCE_CC_C |=> jump_taken == $past(flags_out[FCE_C_BIT]); endproperty
    a_carry: assert property (p_carry) else $error("carry code wrong");
    property p_sel; op_valid && op_code == FCE_OP_SDM |=> data_space_sel; endproperty
    a_sel: assert property (p_sel) else $error("space select mismatch");
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("access not answered");
    property p_drop; pready |=> !pready; endproperty
    a_drop: assert property (p_drop) else $error("ready held too long");
endmodule : fce_flags_checker
bind fce_flags fce_flags_checker fce_flags_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_code(op_code), .op_result(op_result), .cond_code(cond_code),
    .flags_out(flags_out), .jump_taken(jump_taken), .data_space_sel(data_space_sel),
    .flags_undefined(flags_undefined)
);

// ---- fce_core_model.sv ----
// Purpose: Behavioural decoder and ALU that feed the flag block.
// Assumes: One completed instruction per call, pulse of one cycle.
// Notes: Idle result lines carry the inverse so stale data never looks fresh.
`timescale 1ns/1ps
module fce_core_model (
    // Clock.
    input wire logic pclk,
    // Decoder outputs.
    output logic op_valid,
    output fce_pkg::fce_op_type op_code,
    output fce_pkg::fce_result_type op_result,
    output logic [3:0] cond_code
);
    import fce_pkg::*;
    // Quiet start: no instruction and the never-jump code.
    initial begin
        op_valid = 1'b0;
        op_code = FCE_OP_NONE;
        op_result = '0;
        cond_code = FCE_CC_F;
    end
    // The bits argument packs carry, half, overflow, word and flag-target.
    task automatic issue(input fce_op_type op, input logic [15:0] v, input logic [4:0] b);
        @(posedge pclk);
        op_valid <= 1'b1;
        op_code <= op;
        op_result <= {v, b};
        @(posedge pclk);
        op_valid <= 1'b0;
        op_code <= FCE_OP_NONE;
        op_result <= ~{v, b};
    endtask : issue
    // Presents one condition field and lets the capture edge pass.
    task automatic set_cond(input logic [3:0] cc);
        @(posedge pclk);
        cond_code <= cc;
        @(posedge pclk);
    endtask : set_cond
endmodule : fce_core_model

// ---- test_fce_flags.sv ----
// Purpose: Self-checking bench for the flag register and condition logic.
// Assumes: APB slave with a registered answer; decoder model drives the core side.
// Notes: Expected flags are worked out by hand from the flag rules.
`timescale 1ns/1ps
module test_fce_flags;
    import fce_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, op_valid, jump_taken, data_space_sel, flags_undefined, er;
    fce_op_type op_code;
    fce_result_type op_result;
    logic [3:0] cond_code;
    logic [7:0] flags_out;
    logic [7:0] pats [7] = '{8'h00, 8'hff, 8'h40, 8'h20, 8'h10, 8'h80, 8'h30};
    int bad_count = 0;
    int num_checks = 0;
    always #5 pclk = ~pclk;
    fce_flags fce_flags_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .op_result(op_result),
        .cond_code(cond_code), .flags_out(flags_out), .jump_taken(jump_taken),
        .data_space_sel(data_space_sel), .flags_undefined(flags_undefined));
    fce_core_model fce_core_model_inst (.pclk(pclk), .op_valid(op_valid), .op_code(op_code),
        .op_result(op_result), .cond_code(cond_code));
    // One APB transfer; it waits on pready and only the watchdog ends a wait.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask : chk_bit
    // Issues one instruction and compares the whole flag byte afterwards.
    task automatic op_chk(input fce_op_type op, input logic [15:0] v, input logic [4:0] b,
        input logic [7:0] exp);
        fce_core_model_inst.issue(op, v, b);
        #1;
        chk_val({24'h0, flags_out}, {24'h0, exp});
    endtask : op_chk
    // Bit 3 of the code inverts the sense of the low three bits.
    function automatic logic exp_cond(input logic [3:0] cc, input logic [7:0] f);
        logic lt;
        logic r;
        lt = f[FCE_S_BIT] ^ f[FCE_V_BIT];
        case (cc[2:0])
            3'h0: r = 1'b0;
            3'h1: r = lt;
            3'h2: r = f[FCE_Z_BIT] | lt;
            3'h3: r = f[FCE_C_BIT] | f[FCE_Z_BIT];
            3'h4: r = f[FCE_V_BIT];
            3'h5: r = f[FCE_S_BIT];
            3'h6: r = f[FCE_Z_BIT];
            default: r = f[FCE_C_BIT];
        endcase
        return r ^ cc[3];
    endfunction : exp_cond
    task automatic summarize;
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // Watchdog sized well above the few hundred cycles the run needs.
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk_bit(flags_undefined, 1'b1);
        apb(1'b1, FCE_FLAGS_ADDR, 32'h0000_00a5);
        apb(1'b0, FCE_FLAGS_ADDR, 32'h0);
        chk_val(rd, 32'h0000_00a5);
        chk_bit(data_space_sel, 1'b1);
        chk_bit(flags_undefined, 1'b0);
        apb(1'b0, 12'hff0, 32'h0);
        chk_bit(er, 1'b1);
        apb(1'b1, FCE_FLAGS_ADDR, 32'h0000_0002);
        op_chk(FCE_OP_ADD, 16'h0000, 5'b11000, 8'hc6);
        op_chk(FCE_OP_SUB, 16'h8001, 5'b00110, 8'h36);
        op_chk(FCE_OP_SUB, 16'h0080, 5'b10000, 8'haa);
        op_chk(FCE_OP_LOGIC, 16'h0000, 5'b00000, 8'hca);
        op_chk(FCE_OP_RCF, 16'h0000, 5'b00000, 8'h4a);
        op_chk(FCE_OP_SCF, 16'h0000, 5'b00000, 8'hca);
        op_chk(FCE_OP_CCF, 16'h0000, 5'b00000, 8'h4a);
        op_chk(FCE_OP_SDM, 16'h0000, 5'b00000, 8'h4b);
        chk_bit(data_space_sel, 1'b1);
        op_chk(FCE_OP_SPM, 16'h0000, 5'b00000, 8'h4a);
        op_chk(FCE_OP_CLRU, 16'h0000, 5'b00000, 8'h48);
        op_chk(FCE_OP_SETU, 16'h0000, 5'b00000, 8'h4a);
        fce_core_model_inst.issue(FCE_OP_ADD, 16'h0001, 5'b00001);
        #1;
        chk_bit(flags_undefined, 1'b1);
        // Every condition code against flag patterns that split each term.
        foreach (pats[i]) begin
            apb(1'b1, FCE_FLAGS_ADDR, {24'h0, pats[i]});
            for (int c = 0; c < 16; c++) begin
                fce_core_model_inst.set_cond(c[3:0]);
                #1;
                chk_bit(jump_taken, exp_cond(c[3:0], pats[i]));
            end
        end
        // Flags now hold 8'h30: sign and overflow set, carry and zero clear.
        fce_core_model_inst.set_cond(FCE_CC_MI);
        #1;
        chk_bit(jump_taken, 1'b1);
        fce_core_model_inst.set_cond(FCE_CC_LT);
        #1;
        chk_bit(jump_taken, 1'b0);
        fce_core_model_inst.set_cond(FCE_CC_UGT);
        #1;
        chk_bit(jump_taken, 1'b1);
        apb(1'b0, FCE_COND_ADDR, 32'h0);
        chk_val(rd, 32'h0000_010b);
        // Next address 1000h, displacement -128, bit index 5, single register.
        apb(1'b1, FCE_OPND_ADDR, 32'h1000_8005);
        apb(1'b0, FCE_NOTATION_ADDR, 32'h0);
        chk_val(rd, 32'h0041_0f80);
        // Next address 0011h, displacement +127, odd pair register, bit index 3.
        apb(1'b1, FCE_OPND_ADDR, 32'h0011_7f03);
        apb(1'b0, FCE_NOTATION_ADDR, 32'h0);
        chk_val(rd, 32'h0010_0090);
        chk_bit(flags_undefined, 1'b0);
        summarize();
    end
endmodule : test_fce_flags
